// ---- rtl/rmcds_pkg.sv ----
package rmcds_pkg;

  // Register byte addresses on the slave port.
  localparam logic [7:0] RMCDS_ADDR_RUN_CFG = 8'h60;
  localparam logic [7:0] RMCDS_ADDR_OVR_CFG = 8'h70;
  localparam logic [7:0] RMCDS_ADDR_STATUS = 8'h74;

  // Run-mode configuration field positions.
  localparam int RMCDS_SYSTEM_DIVISOR_FIELD_LSB = 23;
  localparam int RMCDS_SYSTEM_DIVISOR_FIELD_MSB = 26;
  localparam int RMCDS_USE_SYSTEM_DIVISOR_FIELD_BIT = 22;
  localparam int RMCDS_USE_PWM_DIVISOR_FIELD_BIT = 20;
  localparam int RMCDS_PWM_DIVISOR_FIELD_LSB = 17;
  localparam int RMCDS_PWM_DIVISOR_FIELD_MSB = 19;
  localparam int RMCDS_PLL_POWER_DOWN_BIT = 13;
  localparam int RMCDS_RSVD_ONE_BIT = 12;
  localparam int RMCDS_BYPASS_BIT = 11;
  localparam int RMCDS_BASE_INPUT_SOURCE_FIELD_LSB = 4;
  localparam int RMCDS_BASE_INPUT_SOURCE_FIELD_MSB = 5;

  // Override configuration field positions.
  localparam int RMCDS_OVR_EN_BIT = 31;
  localparam int RMCDS_OVR_DIV_LSB = 23;
  localparam int RMCDS_OVR_DIV_MSB = 26;

  // Status field positions.
  localparam int RMCDS_ST_DIV_LSB = 0;
  localparam int RMCDS_ST_DIV_MSB = 3;
  localparam int RMCDS_ST_DIV_ACTIVE_BIT = 4;
  localparam int RMCDS_ST_PLL_SEL_BIT = 5;
  localparam int RMCDS_ST_CLAMPED_BIT = 6;

  // Reset values.
  localparam logic [3:0] RMCDS_SYSTEM_DIVISOR_FIELD_RST = 4'hf;
  localparam logic [2:0] RMCDS_PWM_DIVISOR_FIELD_RST = 3'h7;
  localparam logic [1:0] RMCDS_BASE_INPUT_SOURCE_FIELD_RST = 2'h1;
  localparam logic [3:0] RMCDS_OVR_DIV_RST = 4'hf;

  // Base input source codes.
  localparam logic [1:0] RMCDS_SRC_MAIN_CRYSTAL = 2'h0;
  localparam logic [1:0] RMCDS_SRC_INTERNAL = 2'h1;

  // Largest PWM divider exponent index (divide by 64).
  localparam logic [2:0] RMCDS_PWM_DIVISOR_FIELD_MAX = 3'h5;

  typedef struct packed {
    logic [3:0] system_divisor_field;
    logic divider_use_bit;
    logic pwm_divider_use_bit;
    logic [2:0] pwm_divisor_field;
    logic pll_power_down;
    logic pll_skip;
    logic [1:0] base_input_source_field;
  } rmcds_run_cfg_t;

  typedef struct packed {
    logic override_enable_bit;
    logic [3:0] override_divisor_field;
  } rmcds_ovr_cfg_t;

  localparam rmcds_run_cfg_t RMCDS_RUN_CFG_RST = '{
    system_divisor_field: RMCDS_SYSTEM_DIVISOR_FIELD_RST,
    divider_use_bit: 1'b0,
    pwm_divider_use_bit: 1'b0,
    pwm_divisor_field: RMCDS_PWM_DIVISOR_FIELD_RST,
    pll_power_down: 1'b1,
    pll_skip: 1'b1,
    base_input_source_field: RMCDS_BASE_INPUT_SOURCE_FIELD_RST
  };

  localparam rmcds_ovr_cfg_t RMCDS_OVR_CFG_RST = '{
    override_enable_bit: 1'b0,
    override_divisor_field: RMCDS_OVR_DIV_RST
  };

  // Clock selection handed to the clock tree.
  typedef struct packed {
    logic pll_selected;
    logic divider_active;
    logic [3:0] divisor_code;
    logic [1:0] base_input_source;
  } rmcds_clk_sel_t;

endpackage : rmcds_pkg

// ---- rtl/rmcds_top.sv ----
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
module rmcds_top
  import rmcds_pkg::*;
(
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_i,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Device limit on the PLL divisor.
  input wire logic [3:0] minimum_system_divisor_i,
  // Clock tree controls.
  output logic pll_power_down_o,
  output rmcds_clk_sel_t clk_sel_o,
  // PWM timing clock.
  output logic pwm_divider_use_o,
  output logic pwm_clk_o,
  output logic pwm_tick_o
);

  rmcds_run_cfg_t run_cfg_reg, run_cfg_next;
  rmcds_ovr_cfg_t ovr_cfg_reg, ovr_cfg_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [5:0] pwm_cnt_reg, pwm_cnt_next;
  logic pwm_clk_reg, pwm_clk_next;
  logic pwm_tick_reg, pwm_tick_next;
  rmcds_clk_sel_t sel_reg, sel_next;
  logic clamped_reg, clamped_next;

  logic req;
  logic [31:0] run_word;
  logic [31:0] ovr_word;
  logic [31:0] status_word;
  logic [31:0] run_wr;
  logic [31:0] ovr_wr;
  logic [31:0] be_mask;

  assign req = avs_read_i | avs_write_i;
  // One wait cycle: the answer comes on the second cycle of every request.
  assign avs_waitrequest_o = req & ~ack_reg;
  assign avs_readdata_o = rdata_reg;
  assign pll_power_down_o = run_cfg_reg.pll_power_down;
  assign clk_sel_o = sel_reg;
  assign pwm_divider_use_o = run_cfg_reg.pwm_divider_use_bit;
  assign pwm_clk_o = pwm_clk_reg;
  assign pwm_tick_o = pwm_tick_reg;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_be
      assign be_mask[g*8 +: 8] = {8{avs_byteenable_i[g]}};
    end
  endgenerate

  // Register images as software sees them.
  always_comb begin
    run_word = '0;
    run_word[RMCDS_SYSTEM_DIVISOR_FIELD_MSB:RMCDS_SYSTEM_DIVISOR_FIELD_LSB] = run_cfg_reg.system_divisor_field;
    run_word[RMCDS_USE_SYSTEM_DIVISOR_FIELD_BIT] = run_cfg_reg.divider_use_bit;
    run_word[RMCDS_USE_PWM_DIVISOR_FIELD_BIT] = run_cfg_reg.pwm_divider_use_bit;
    run_word[RMCDS_PWM_DIVISOR_FIELD_MSB:RMCDS_PWM_DIVISOR_FIELD_LSB] = run_cfg_reg.pwm_divisor_field;
    run_word[RMCDS_PLL_POWER_DOWN_BIT] = run_cfg_reg.pll_power_down;
    run_word[RMCDS_RSVD_ONE_BIT] = 1'b1;
    run_word[RMCDS_BYPASS_BIT] = run_cfg_reg.pll_skip;
    run_word[RMCDS_BASE_INPUT_SOURCE_FIELD_MSB:RMCDS_BASE_INPUT_SOURCE_FIELD_LSB] = run_cfg_reg.base_input_source_field;
    ovr_word = '0;
    ovr_word[RMCDS_OVR_EN_BIT] = ovr_cfg_reg.override_enable_bit;
    ovr_word[RMCDS_OVR_DIV_MSB:RMCDS_OVR_DIV_LSB] = ovr_cfg_reg.override_divisor_field;
    status_word = '0;
    status_word[RMCDS_ST_DIV_MSB:RMCDS_ST_DIV_LSB] = sel_reg.divisor_code;
    status_word[RMCDS_ST_DIV_ACTIVE_BIT] = sel_reg.divider_active;
    status_word[RMCDS_ST_PLL_SEL_BIT] = sel_reg.pll_selected;
    status_word[RMCDS_ST_CLAMPED_BIT] = clamped_reg;
    run_wr = (run_word & ~be_mask) | (avs_writedata_i & be_mask);
    ovr_wr = (ovr_word & ~be_mask) | (avs_writedata_i & be_mask);
  end

  // Bus handshake, read data and register writes.
  always_comb begin
    ack_next = req & ~ack_reg;
    rdata_next = rdata_reg;
    run_cfg_next = run_cfg_reg;
    ovr_cfg_next = ovr_cfg_reg;
    if (avs_read_i && !ack_reg) begin
      unique case (avs_address_i)
        RMCDS_ADDR_RUN_CFG: rdata_next = run_word;
        RMCDS_ADDR_OVR_CFG: rdata_next = ovr_word;
        RMCDS_ADDR_STATUS: rdata_next = status_word;
        default: rdata_next = '0;
      endcase
    end
    if (avs_write_i && ack_reg) begin
      if (avs_address_i == RMCDS_ADDR_RUN_CFG) begin
        run_cfg_next.system_divisor_field = run_wr[RMCDS_SYSTEM_DIVISOR_FIELD_MSB:RMCDS_SYSTEM_DIVISOR_FIELD_LSB];
        run_cfg_next.divider_use_bit = run_wr[RMCDS_USE_SYSTEM_DIVISOR_FIELD_BIT];
        run_cfg_next.pwm_divider_use_bit = run_wr[RMCDS_USE_PWM_DIVISOR_FIELD_BIT];
        run_cfg_next.pwm_divisor_field = run_wr[RMCDS_PWM_DIVISOR_FIELD_MSB:RMCDS_PWM_DIVISOR_FIELD_LSB];
        run_cfg_next.pll_power_down = run_wr[RMCDS_PLL_POWER_DOWN_BIT];
        run_cfg_next.pll_skip = run_wr[RMCDS_BYPASS_BIT];
        run_cfg_next.base_input_source_field =
          run_wr[RMCDS_BASE_INPUT_SOURCE_FIELD_MSB:RMCDS_BASE_INPUT_SOURCE_FIELD_LSB];
      end
      if (avs_address_i == RMCDS_ADDR_OVR_CFG) begin
        ovr_cfg_next.override_enable_bit = ovr_wr[RMCDS_OVR_EN_BIT];
        ovr_cfg_next.override_divisor_field = ovr_wr[RMCDS_OVR_DIV_MSB:RMCDS_OVR_DIV_LSB];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
      run_cfg_reg <= RMCDS_RUN_CFG_RST;
      ovr_cfg_reg <= RMCDS_OVR_CFG_RST;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
      run_cfg_reg <= run_cfg_next;
      ovr_cfg_reg <= ovr_cfg_next;
    end
  end

  // System clock selection and divisor.
  always_comb begin
    logic [3:0] prog_div;
    prog_div = run_cfg_reg.system_divisor_field;
    if (ovr_cfg_reg.override_enable_bit) begin
      prog_div = ovr_cfg_reg.override_divisor_field;
    end
    sel_next.pll_selected = ~run_cfg_reg.pll_skip;
    sel_next.base_input_source = run_cfg_reg.base_input_source_field;
    // The PLL path always runs through the divider; bypass uses it only on request.
    sel_next.divider_active = ~run_cfg_reg.pll_skip | run_cfg_reg.divider_use_bit;
    clamped_next = 1'b0;
    sel_next.divisor_code = prog_div;
    if (!run_cfg_reg.pll_skip && (prog_div < minimum_system_divisor_i)) begin
      sel_next.divisor_code = minimum_system_divisor_i;
      clamped_next = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sel_reg <= '{pll_selected: 1'b0, divider_active: 1'b0,
                   divisor_code: RMCDS_SYSTEM_DIVISOR_FIELD_RST, base_input_source: RMCDS_BASE_INPUT_SOURCE_FIELD_RST};
      clamped_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      clamped_reg <= clamped_next;
    end
  end

  // PWM divider: a free counter whose bit n is a square wave at clock/2^(n+1).
  always_comb begin
    logic [2:0] idx;
    logic [5:0] mask;
    idx = run_cfg_reg.pwm_divisor_field;
    if (idx > RMCDS_PWM_DIVISOR_FIELD_MAX) begin
      idx = RMCDS_PWM_DIVISOR_FIELD_MAX;
    end
    mask = 6'(({1'b0, 6'h3f} >> (RMCDS_PWM_DIVISOR_FIELD_MAX - idx)));
    pwm_cnt_next = pwm_cnt_reg + 6'h01;
    // Registered from the next count so edges land on system clock edges.
    pwm_clk_next = pwm_cnt_next[idx];
    pwm_tick_next = 1'b1;
    if (run_cfg_reg.pwm_divider_use_bit) begin
      pwm_tick_next = ((pwm_cnt_next & mask) == (mask ^ (mask >> 1)));
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pwm_cnt_reg <= '0;
      pwm_clk_reg <= 1'b0;
      pwm_tick_reg <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_next;
      pwm_clk_reg <= pwm_clk_next;
      pwm_tick_reg <= pwm_tick_next;
    end
  end

endmodule // rmcds_top

// ---- bench/rmcds_top_asserts.sv ----
module rmcds_top_asserts
  import rmcds_pkg::*;
(
  // Watched ports.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [3:0] minimum_system_divisor_i,
  input wire logic pll_power_down_o,
  input wire rmcds_clk_sel_t clk_sel_o,
  input wire logic pwm_divider_use_o,
  input wire logic pwm_clk_o,
  input wire logic pwm_tick_o
);
  logic [6:0] run_reg, run_next;
  logic prev_reg, prev_next;
  // Counts cycles since the PWM clock last changed level.
  always_comb begin
    prev_next = pwm_clk_o;
    run_next = (pwm_clk_o != prev_reg) ? 7'h0 : run_reg + 7'h1;
  end
  always_ff @(posedge clock_i) begin
    run_reg <= rst_i ? 7'h0 : run_next;
    prev_reg <= prev_next;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_pll_forces_div: assert property (clk_sel_o.pll_selected |-> clk_sel_o.divider_active)
    else $error("pll path without divider");
  chk_clamp_floor: assert property (clk_sel_o.pll_selected && $stable(minimum_system_divisor_i)
    |-> clk_sel_o.divisor_code >= minimum_system_divisor_i) else $error("divisor under minimum");
  chk_reset_state: assert property ($fell(rst_i) |-> pll_power_down_o
    && clk_sel_o == 8'h3d && !pwm_clk_o) else $error("bad state after reset");
  chk_wait_one: assert property ($rose(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait not one cycle");
  chk_idle_nowait: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait while idle");
  chk_tick_level: assert property (!pwm_divider_use_o [*3] |-> pwm_tick_o)
    else $error("undivided tick missing");
  chk_tick_pulse: assert property (pwm_divider_use_o [*4] ##0 pwm_tick_o |=> !pwm_tick_o)
    else $error("tick wider than one cycle");
  chk_pwm_toggles: assert property (run_reg < 7'h40)
    else $error("pwm clock stuck");
  cover property ($rose(avs_write_i));
  cover property (clk_sel_o.pll_selected);
  cover property (pwm_divider_use_o && pwm_tick_o);
endmodule // rmcds_top_asserts
bind rmcds_top rmcds_top_asserts u_chk (.clock_i, .rst_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .minimum_system_divisor_i, .pll_power_down_o, .clk_sel_o,
  .pwm_divider_use_o, .pwm_clk_o, .pwm_tick_o);

// ---- bench/rmcds_far_model.sv ----
module rmcds_far_model
  import rmcds_pkg::*;
#(parameter logic [3:0] MIN_DIV = 4'h3)
(
  // Clock and block controls.
  input wire logic clock_i,
  input wire logic pwm_tick_i,
  // Device limit and PWM tick count.
  output logic [3:0] min_div_o,
  output int tick_count_o
);
  // Software side keeps the converter on a PLL-derived clock, so the floor stays fixed.
  assign min_div_o = MIN_DIV;
  initial tick_count_o = 0;
  always @(posedge clock_i) if (pwm_tick_i) tick_count_o <= tick_count_o + 1;
endmodule // rmcds_far_model

// ---- bench/tb.sv ----
module tb;
  import rmcds_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [7:0] avs_address_i;
  logic [3:0] avs_byteenable_i, minimum_system_divisor_i, c;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, run_m, ovr_m;
  logic pll_power_down_o, pwm_divider_use_o, pwm_clk_o, pwm_tick_o, pll, cl;
  rmcds_clk_sel_t clk_sel_o;
  int fail_count, checks_done, seed, ticks, t0, r;
  localparam logic [7:0] ADR [4] = '{8'h60, 8'h70, 8'h74, 8'h44};
  rmcds_top dut (.clock_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .minimum_system_divisor_i, .pll_power_down_o, .clk_sel_o, .pwm_divider_use_o,
    .pwm_clk_o, .pwm_tick_o);
  rmcds_far_model u_far (.clock_i, .pwm_tick_i(pwm_tick_o),
    .min_div_o(minimum_system_divisor_i), .tick_count_o(ticks));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until the edge at which waitrequest is low, then releases it.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= w;
    avs_read_i <= !w;
    #1;
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 20) begin
        fail_count++;
        tally_and_finish;
      end
      @(posedge clock_i);
      #1;
    end
    q = avs_readdata_o;
    @(posedge clock_i);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    bus(1'b1, a, d, be);
    if (a == 8'h60) run_m = ((run_m & ~m) | (d & m)) & 32'h07de2830 | 32'h00001000;
    if (a == 8'h70) ovr_m = ((ovr_m & ~m) | (d & m)) & 32'h87800000;
    pll = !run_m[11];
    c = ovr_m[31] ? ovr_m[26:23] : run_m[26:23];
    cl = pll && c < 4'h3;
    if (cl) c = 4'h3;
    @(posedge clock_i);
    #1;
    cmp(clk_sel_o, {pll, run_m[22] | pll, c, run_m[5:4]});
    cmp({pll_power_down_o, pwm_divider_use_o}, {run_m[13], run_m[20]});
    @(posedge clock_i);
    bus(1'b0, 8'h60, 32'h0, 4'hf);
    cmp(q, run_m);
    bus(1'b0, 8'h70, 32'h0, 4'hf);
    cmp(q, ovr_m);
    bus(1'b0, 8'h74, 32'h0, 4'hf);
    cmp(q, {cl, pll, run_m[22] | pll, c});
    bus(1'b0, 8'h44, 32'h0, 4'hf);
    cmp(q, 32'h0);
  endtask
  initial begin
    seed = 30490;
    fail_count = 0;
    checks_done = 0;
    {rst_i, avs_read_i, avs_write_i, avs_address_i} = 11'h400;
    {avs_byteenable_i, avs_writedata_i} = 36'h0;
    for (int k = 0; k < 2; k++) begin
      run_m = 32'h078e3810;
      ovr_m = 32'h07800000;
      repeat (20) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      wr_chk(8'h44, $random(seed), 4'hf);
      for (int i = 0; i < 40; i++) begin
        r = $random(seed);
        wr_chk(ADR[r[1:0]], $random(seed), r[7:4]);
      end
      for (int i = 0; i < 9; i++) begin
        wr_chk(8'h60, {run_m[31:21], i < 8, i[2:0], run_m[16:0]}, 4'hf);
        repeat (70) @(posedge clock_i);
        t0 = ticks;
        repeat (128) @(posedge clock_i);
        cmp(ticks - t0, i < 8 ? 128 >> ((i > 5 ? 5 : i) + 1) : 128);
      end
      rst_i <= 1'b1;
    end
    tally_and_finish;
  end
endmodule // tb
